// file: shared/cnr_cfg.svh
// Offsets, encodings, field positions and reset values for the core slice.
// Assumes it is included once per file by its bare name.
`ifndef CNR_CFG_SVH
`define CNR_CFG_SVH

`define CNR_OP_NOP        16'h0000
`define CNR_OP_RETURN     16'h0002
`define CNR_OP_IRET       16'h0005
`define CNR_OP_NEG_HI     7'h16
`define CNR_OP_LITRET_HI  8'hb6
`define CNR_OP_MUL_HI     8'h34

`define CNR_ST_C          0
`define CNR_ST_DC         1
`define CNR_ST_Z          2
`define CNR_ST_RANGE      3
`define CNR_ST_GID        4
`define CNR_ST_MASK       8'h1f
`define CNR_ST_RST        8'h10

`define CNR_A_ACC         9'h000
`define CNR_A_STAT        9'h001
`define CNR_A_HILATCH     9'h002
`define CNR_A_PROD_LO     9'h003
`define CNR_A_PROD_HI     9'h004
`define CNR_A_PCL         9'h005
`define CNR_A_PCH         9'h006
`define CNR_A_SP          9'h007
`define CNR_A_PUSH        9'h008
`define CNR_A_PUSHHI      9'h009
`define CNR_A_CTRL        9'h00a

`endif

// file: shared/cnr_pkg.sv
// Types shared by the core slice and its register port.
// Assumes the configuration header supplies all numeric constants.
package cnr_pkg;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cnr_bus_req_t;

    typedef enum logic [2:0] {
        OP_NOP, OP_NEG, OP_IRET, OP_LITRET, OP_RETURN, OP_MUL, OP_OTHER
    } cnr_op_t;

    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} cnr_phase_t;

endpackage : cnr_pkg

// file: logic/cnr_ram.sv
// Two-port memory with registered read data on both ports.
// Assumes both ports share clk; port A wins a same-address write collision.
`timescale 1ns/1ns
module cnr_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input  wire logic          clk,
    input  wire logic [AW-1:0] aAddr,
    input  wire logic [DW-1:0] aWdata,
    input  wire logic          aWe,
    output logic      [DW-1:0] aRdata_r,
    input  wire logic [AW-1:0] bAddr,
    input  wire logic [DW-1:0] bWdata,
    input  wire logic          bWe,
    output logic      [DW-1:0] bRdata_r
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk)
    begin
        aRdata_r <= mem[aAddr];
        bRdata_r <= mem[bAddr];
        if (bWe)
        begin
            mem[bAddr] <= bWdata;
        end
        if (aWe)
        begin
            mem[aAddr] <= aWdata;
        end
    end
endmodule : cnr_ram

// file: logic/cnr_core.sv
// Core slice: negate, no-op and the three returns, plus multiply.
// Assumes progWord follows progAddr combinationally, valid in quarter one.
// What this block does
// - Negate accumulator by invert plus one
// - Select zero writes accumulator and file
// - Select one writes file only
// - Negate updates range, carry, digit, zero
// - Negate is one word, one cycle
// - Interrupt return pops stack into PC
// - Interrupt return clears interrupt disable only
// - Interrupt disable sits at status bit four
// - Interrupt return: clear Q3, pop Q4
// - Literal return loads literal, flags kept
// - Literal return pops in Q4, two cycles
// - Returns never touch the PC high latch
// - Subroutine return keeps every status flag
// - Subroutine return pops in Q4, two cycles
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`include "cnr_cfg.svh"
module cnr_core (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire cnr_pkg::cnr_bus_req_t busReq,
    output logic [7:0]                 busRdata,
    output logic [15:0]                progAddr,
    input  wire logic [15:0]           progWord
);
    cnr_pkg::cnr_phase_t q_r, q_nxt;
    cnr_pkg::cnr_op_t    op;
    logic        cyc2_r, cyc2_nxt, run_r, run_nxt, rdFile_r, rdFile_nxt;
    logic [15:0] instr_r, instr_nxt, pc_r, pc_nxt, res_r, res_nxt;
    logic [7:0]  acc_r, acc_nxt, stat_r, stat_nxt, hiLatch_r, hiLatch_nxt;
    logic [7:0]  prodLo_r, prodLo_nxt, prodHi_r, prodHi_nxt;
    logic [7:0]  pushHi_r, pushHi_nxt, rdReg_r, rdReg_nxt;
    logic [3:0]  sp_r, sp_nxt;
    logic [7:0]  fileData, busFileData;
    logic [15:0] stackTop;
    logic        fileWe, pushWe;

    function automatic cnr_pkg::cnr_op_t decode(input logic [15:0] w);
        if (w == `CNR_OP_NOP)
            decode = cnr_pkg::OP_NOP;
        else if (w == `CNR_OP_IRET)
            decode = cnr_pkg::OP_IRET;
        else if (w == `CNR_OP_RETURN)
            decode = cnr_pkg::OP_RETURN;
        else if (w[15:9] == `CNR_OP_NEG_HI)
            decode = cnr_pkg::OP_NEG;
        else if (w[15:8] == `CNR_OP_LITRET_HI)
            decode = cnr_pkg::OP_LITRET;
        else if (w[15:8] == `CNR_OP_MUL_HI)
            decode = cnr_pkg::OP_MUL;
        else
            decode = cnr_pkg::OP_OTHER;
    endfunction : decode

    function automatic logic [7:0] negate(input logic [7:0] a);
        negate = ~a + 8'h01;
    endfunction : negate

    assign op       = decode(instr_r);
    assign progAddr = pc_r;
    assign busRdata = rdFile_r ? busFileData : rdReg_r;
    // The core writes the file only in quarter four of a single-cycle negate; software writes go through port B.
    assign fileWe   = run_r && q_r == cnr_pkg::Q4 && !cyc2_r
                      && op == cnr_pkg::OP_NEG;
    assign pushWe   = busReq.wr && busReq.addr == `CNR_A_PUSH;

    cnr_ram #(.AW(8), .DW(8)) fileRam (
        .clk      (clk),
        .aAddr    (instr_r[7:0]),
        .aWdata   (res_r[7:0]),
        .aWe      (fileWe),
        .aRdata_r (fileData),
        .bAddr    (busReq.addr[7:0]),
        .bWdata   (busReq.wdata),
        .bWe      (busReq.wr && busReq.addr[8]),
        .bRdata_r (busFileData)
    );

    // The stack read port always shows the entry below the pointer, so
    // the top is ready long before quarter four needs it.
    cnr_ram #(.AW(4), .DW(16)) stackRam (
        .clk      (clk),
        .aAddr    (sp_r - 4'h1),
        .aWdata   (16'h0000),
        .aWe      (1'b0),
        .aRdata_r (stackTop),
        .bAddr    (sp_r),
        .bWdata   ({pushHi_r, busReq.wdata}),
        .bWe      (pushWe),
        .bRdata_r ()
    );

    always_comb
    begin
        q_nxt      = q_r;
        cyc2_nxt   = cyc2_r;
        run_nxt    = run_r;
        instr_nxt  = instr_r;
        pc_nxt     = pc_r;
        res_nxt    = res_r;
        acc_nxt    = acc_r;
        stat_nxt   = stat_r;
        hiLatch_nxt = hiLatch_r;
        prodLo_nxt  = prodLo_r;
        prodHi_nxt  = prodHi_r;
        pushHi_nxt = pushHi_r;
        sp_nxt     = sp_r;
        rdReg_nxt  = 8'h00;
        rdFile_nxt = busReq.rd && busReq.addr[8];
        // Software writes come first so that the core's own updates in
        // the same cycle take precedence over them.
        if (busReq.wr && !busReq.addr[8])
        begin
            case (busReq.addr)
                `CNR_A_ACC:    acc_nxt    = busReq.wdata;
                `CNR_A_STAT:   stat_nxt   = busReq.wdata & `CNR_ST_MASK;
                `CNR_A_HILATCH: hiLatch_nxt = busReq.wdata;
                `CNR_A_PROD_LO: prodLo_nxt  = busReq.wdata;
                `CNR_A_PROD_HI: prodHi_nxt  = busReq.wdata;
                `CNR_A_PCL:    pc_nxt[7:0]  = busReq.wdata;
                `CNR_A_PCH:    pc_nxt[15:8] = busReq.wdata;
                `CNR_A_PUSH:   sp_nxt     = sp_r + 4'h1;
                `CNR_A_PUSHHI: pushHi_nxt = busReq.wdata;
                `CNR_A_CTRL:   run_nxt    = busReq.wdata[0];
                default:       ;
            endcase
        end
        if (busReq.rd && !busReq.addr[8])
        begin
            case (busReq.addr)
                `CNR_A_ACC:    rdReg_nxt = acc_r;
                `CNR_A_STAT:   rdReg_nxt = stat_r;
                `CNR_A_HILATCH: rdReg_nxt = hiLatch_r;
                `CNR_A_PROD_LO: rdReg_nxt = prodLo_r;
                `CNR_A_PROD_HI: rdReg_nxt = prodHi_r;
                `CNR_A_PCL:    rdReg_nxt = pc_r[7:0];
                `CNR_A_PCH:    rdReg_nxt = pc_r[15:8];
                `CNR_A_SP:     rdReg_nxt = {4'h0, sp_r};
                `CNR_A_PUSHHI: rdReg_nxt = pushHi_r;
                `CNR_A_CTRL:   rdReg_nxt = {7'h00, run_r};
                default:       rdReg_nxt = 8'h00;
            endcase
        end
        if (run_r)
        begin
            unique case (q_r)
                cnr_pkg::Q1:
                begin
                    // Decode: the second cycle of a return fetches nothing.
                    if (!cyc2_r)
                        instr_nxt = progWord;
                    q_nxt = cnr_pkg::Q2;
                end
                cnr_pkg::Q2:
                begin
                    // Read: the file address drives the memory this quarter.
                    q_nxt = cnr_pkg::Q3;
                end
                cnr_pkg::Q3:
                begin
                    q_nxt = cnr_pkg::Q4;
                    if (!cyc2_r)
                    begin
                        if (op == cnr_pkg::OP_NEG)
                            res_nxt = {8'h00, negate(acc_r)};
                        if (op == cnr_pkg::OP_MUL)
                            res_nxt = {8'h00, acc_r} * {8'h00, fileData};
                        if (op == cnr_pkg::OP_IRET)
                            stat_nxt[`CNR_ST_GID] = 1'b0;
                    end
                end
                cnr_pkg::Q4:
                begin
                    q_nxt = cnr_pkg::Q1;
                    if (cyc2_r)
                        cyc2_nxt = 1'b0;
                    else
                    begin
                        unique case (op)
                            cnr_pkg::OP_NEG:
                            begin
                                if (!instr_r[8])
                                    acc_nxt = res_r[7:0];
                                stat_nxt[`CNR_ST_C]  = acc_r == 8'h00;
                                stat_nxt[`CNR_ST_DC] = acc_r[3:0] == 4'h0;
                                stat_nxt[`CNR_ST_Z]  = res_r[7:0] == 8'h00;
                                stat_nxt[`CNR_ST_RANGE] = acc_r == 8'h80;
                                pc_nxt = pc_r + 16'h0001;
                            end
                            cnr_pkg::OP_IRET, cnr_pkg::OP_RETURN,
                            cnr_pkg::OP_LITRET:
                            begin
                                // The high latch and the flags stay as
                                // they are on purpose.
                                pc_nxt   = stackTop;
                                sp_nxt   = sp_r - 4'h1;
                                cyc2_nxt = 1'b1;
                                if (op == cnr_pkg::OP_LITRET)
                                    acc_nxt = instr_r[7:0];
                            end
                            cnr_pkg::OP_MUL:
                            begin
                                prodHi_nxt = res_r[15:8];
                                prodLo_nxt = res_r[7:0];
                                pc_nxt    = pc_r + 16'h0001;
                            end
                            cnr_pkg::OP_NOP, cnr_pkg::OP_OTHER:
                                pc_nxt = pc_r + 16'h0001;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            q_r      <= cnr_pkg::Q1;
            cyc2_r   <= 1'b0;
            run_r    <= 1'b0;
            rdFile_r <= 1'b0;
            instr_r  <= 16'h0000;
            pc_r     <= 16'h0000;
            res_r    <= 16'h0000;
            acc_r    <= 8'h00;
            stat_r   <= `CNR_ST_RST;
            hiLatch_r <= 8'h00;
            prodLo_r  <= 8'h00;
            prodHi_r  <= 8'h00;
            pushHi_r <= 8'h00;
            rdReg_r  <= 8'h00;
            sp_r     <= 4'h0;
        end
        else
        begin
            q_r      <= q_nxt;
            cyc2_r   <= cyc2_nxt;
            run_r    <= run_nxt;
            rdFile_r <= rdFile_nxt;
            instr_r  <= instr_nxt;
            pc_r     <= pc_nxt;
            res_r    <= res_nxt;
            acc_r    <= acc_nxt;
            stat_r   <= stat_nxt;
            hiLatch_r <= hiLatch_nxt;
            prodLo_r  <= prodLo_nxt;
            prodHi_r  <= prodHi_nxt;
            pushHi_r <= pushHi_nxt;
            rdReg_r  <= rdReg_nxt;
            sp_r     <= sp_nxt;
        end
    end

    // Execution point of the first cycle, with no software write on the bus.
    logic exec4;
    assign exec4 = run_r && q_r == cnr_pkg::Q4 && !cyc2_r && !busReq.wr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_neg_both: assert property (exec4 && op == cnr_pkg::OP_NEG && !instr_r[8]
        |=> acc_r == negate($past(acc_r)))
        else $error("negate with select zero did not load accumulator");
    a_neg_fileonly: assert property (exec4 && op == cnr_pkg::OP_NEG
        && instr_r[8] |=> $stable(acc_r))
        else $error("negate with select one changed accumulator");
    a_neg_flags: assert property (exec4 && op == cnr_pkg::OP_NEG
        |=> stat_r[`CNR_ST_Z] == ($past(acc_r) == 8'h00)
            && stat_r[`CNR_ST_RANGE] == ($past(acc_r) == 8'h80))
        else $error("negate flags wrong");
    a_neg_onecycle: assert property (exec4 && op == cnr_pkg::OP_NEG
        |=> !cyc2_r && pc_r == $past(pc_r) + 16'h0001)
        else $error("negate did not finish in one cycle");
    a_iret_clear: assert property (run_r && q_r == cnr_pkg::Q3 && !cyc2_r
        && op == cnr_pkg::OP_IRET && !busReq.wr
        |=> !stat_r[`CNR_ST_GID] && $stable(stat_r[3:0]))
        else $error("interrupt return did not clear disable bit");
    a_ret_pop: assert property (exec4 && (op == cnr_pkg::OP_IRET
        || op == cnr_pkg::OP_RETURN || op == cnr_pkg::OP_LITRET)
        |=> pc_r == $past(stackTop) && sp_r == $past(sp_r) - 4'h1
            && $stable(hiLatch_r))
        else $error("return did not pop stack into PC");
    a_ret_idle: assert property (exec4 && op == cnr_pkg::OP_RETURN
        && !busReq.rd ##1 !busReq.wr [*4]
        |-> $stable(pc_r) [*4] ##1 !cyc2_r)
        else $error("second return cycle was not idle");
    a_litret_acc: assert property (exec4 && op == cnr_pkg::OP_LITRET
        |=> acc_r == $past(instr_r[7:0]) && $stable(stat_r))
        else $error("literal return wrong");
    a_nop_step: assert property (exec4 && op == cnr_pkg::OP_NOP
        |=> $stable(acc_r) && $stable(stat_r) && $stable(sp_r)
            && pc_r == $past(pc_r) + 16'h0001)
        else $error("no-op changed state");
    a_mul_prod: assert property (exec4 && op == cnr_pkg::OP_MUL
        |=> {prodHi_r, prodLo_r} == $past(res_r)
            && $stable(acc_r))
        else $error("product pair wrong");

    c_neg: cover property (exec4 && op == cnr_pkg::OP_NEG);
    c_iret: cover property (exec4 && op == cnr_pkg::OP_IRET);
    c_litret: cover property (exec4 && op == cnr_pkg::OP_LITRET);
    c_mul: cover property (exec4 && op == cnr_pkg::OP_MUL);
endmodule : cnr_core

// file: dv/tb.sv
// Self-checking bench for the core slice: negate, no-op, returns, multiply.
// Assumes the core fetches from a program memory that follows progAddr.
`timescale 1ns/1ns
`include "cnr_cfg.svh"
module tb;
    logic                  clk;
    logic                  rstn;
    cnr_pkg::cnr_bus_req_t busReq;
    logic [7:0]            busRdata;
    logic [15:0]           progAddr;
    logic [15:0]           progWord;
    logic [15:0]           curWord;
    logic [31:0]           seed;
    int                    errCount;
    int                    nChecks;

    cnr_core dut (
        .clk      (clk),
        .rstn     (rstn),
        .busReq   (busReq),
        .busRdata (busRdata),
        .progAddr (progAddr),
        .progWord (progWord)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Only word zero holds the instruction under test, so every later fetch
    // is a no-op and the program counter trace shows the cycle count. The
    // word follows the address at once, as the core latches it in Q1.
    assign progWord = (progAddr == 16'h0000) ? curWord : `CNR_OP_NOP;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [7:0] neg_stat(input logic [7:0] a,
                                            input logic [7:0] st);
        logic [7:0] r;
        r = ~a + 8'h01;
        return {3'h0, st[`CNR_ST_GID], a == 8'h80, r == 8'h00,
                a[3:0] == 4'h0, a == 8'h00};
    endfunction : neg_stat

    task automatic wrap_up();
        if (errCount == 0 && nChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        nChecks++;
        if (g !== e)
        begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask : wr

    task automatic rchk(input string nm, input logic [8:0] a,
                        input logic [7:0] e);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1;
        chk(nm, {8'h00, e}, {8'h00, busRdata});
    endtask : rchk

    task automatic reset_dut();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
    endtask : reset_dut

    // Runs from address zero and records the first program counter change
    // and the number of clocks until the next one.
    task automatic exec(input logic [15:0] w, output logic [15:0] pc1,
                        output int gap);
        int          t1;
        logic [15:0] prev;
        curWord = w;
        wr(`CNR_A_CTRL, 8'h01);
        prev = progAddr;
        t1 = -1;
        gap = -1;
        pc1 = 16'h0000;
        for (int k = 0; k < 60 && gap < 0; k++)
        begin
            @(posedge clk);
            #1;
            if (progAddr !== prev)
            begin
                if (t1 < 0)
                    pc1 = progAddr;
                else
                    gap = k - t1;
                if (t1 < 0)
                    t1 = k;
                prev = progAddr;
            end
        end
        if (gap < 0)
        begin
            errCount++;
            $display("CHECK FAILED pc trace expected change seen none");
            wrap_up();
        end
        wr(`CNR_A_CTRL, 8'h00);
    endtask : exec

    initial
    begin
        logic [7:0]  acc0, f0, st0, fa, lat, k, neg, eAcc, eSt, eFile;
        logic [15:0] b, w, pc1, prod;
        logic [7:0]  corner [5];
        int          kind;
        int          gap;
        logic        ret;
        rstn = 1'b0;
        busReq = '0;
        curWord = 16'h0000;
        seed = 32'd94998;
        errCount = 0;
        nChecks = 0;
        corner = '{8'h00, 8'h80, 8'h3a, 8'h10, 8'hff};
        reset_dut();
        rchk("reset status", `CNR_A_STAT, `CNR_ST_RST);
        rchk("unmapped", 9'h0ff, 8'h00);
        wr(`CNR_A_PCL, 8'h5a);
        wr(`CNR_A_PCH, 8'hc3);
        rchk("pc low", `CNR_A_PCL, 8'h5a);
        rchk("pc high", `CNR_A_PCH, 8'hc3);
        rchk("ctrl", `CNR_A_CTRL, 8'h00);
        for (int i = 0; i < 49; i++)
        begin
            kind = i % 7;
            ret = kind >= 4;
            reset_dut();
            acc0 = (i < 35) ? corner[i / 7] : 8'(xs());
            f0 = 8'(xs());
            st0 = {3'h0, 5'(xs())};
            fa = 8'(xs());
            lat = 8'(xs());
            k = 8'(xs());
            b = 16'(xs()) | 16'h0100;
            wr(`CNR_A_ACC, acc0);
            wr(`CNR_A_STAT, st0);
            wr(`CNR_A_HILATCH, lat);
            wr({1'b1, fa}, f0);
            wr(`CNR_A_PUSHHI, 8'h7e);
            wr(`CNR_A_PUSH, 8'hd1);
            wr(`CNR_A_PUSHHI, b[15:8]);
            wr(`CNR_A_PUSH, b[7:0]);
            case (kind)
                0: w = {`CNR_OP_NEG_HI, 1'b0, fa};
                1: w = {`CNR_OP_NEG_HI, 1'b1, fa};
                2: w = `CNR_OP_NOP;
                3: w = {`CNR_OP_MUL_HI, fa};
                4: w = {`CNR_OP_LITRET_HI, k};
                5: w = `CNR_OP_IRET;
                default: w = `CNR_OP_RETURN;
            endcase
            neg = ~acc0 + 8'h01;
            eAcc = (kind == 0) ? neg : (kind == 4) ? k : acc0;
            eFile = (kind < 2) ? neg : f0;
            eSt = (kind < 2) ? neg_stat(acc0, st0) :
                  (kind == 5) ? (st0 & 8'hef) : st0;
            prod = (kind == 3) ? 16'(acc0) * 16'(f0) : 16'h0000;
            exec(w, pc1, gap);
            chk("first pc", ret ? b : 16'h0001, pc1);
            chk("cycle gap", ret ? 16'd8 : 16'd4, 16'(gap));
            rchk("acc", `CNR_A_ACC, eAcc);
            rchk("file", {1'b1, fa}, eFile);
            rchk("status", `CNR_A_STAT, eSt);
            rchk("latch", `CNR_A_HILATCH, lat);
            rchk("prod low", `CNR_A_PROD_LO, prod[7:0]);
            rchk("prod high", `CNR_A_PROD_HI, prod[15:8]);
            rchk("sp", `CNR_A_SP, ret ? 8'h01 : 8'h02);
        end
        wrap_up();
    end
endmodule : tb
